/* File: core/serial_chan_ctrl.sv */
/*
 Enable, command and glitch control for one serial channel.
 Software reaches it over a plain register port with read data one
 cycle after the read strobe. Serial clock inputs are synchronous.
*/
`timescale 1ns/1ps
module serial_chan_ctrl (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [serial_chan_pkg::ADDR_W-1:0] addr,
   input wire logic [serial_chan_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [serial_chan_pkg::DATA_W-1:0] rd_data,
   input wire logic rx_clk_in,
   input wire logic tx_clk_in,
   output logic rx_clk_filt,
   output logic tx_clk_filt,
   output logic tx_run,
   output logic rx_run,
   output logic low_power,
   output logic irq,
   output logic cp_reset_out
);
   import serial_chan_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [MODE_W-1:0] mode;
   logic [EVT_W-1:0] event_bits;
   logic [EVT_W-1:0] mask;
   logic [MEM_AW-1:0] tx_ptr;
   logic [MEM_AW-1:0] rx_ptr;
   tx_state_e tx_state;
   tx_state_e next_tx_state;
   rx_state_e rx_state;
   rx_state_e next_rx_state;
   logic tx_en;
   logic rx_en;
   logic glitch_detect_enable;
   logic cmd_wr;
   logic [CMD_W-1:0] cmd;
   logic cmd_reset;
   logic cmd_init_tx;
   logic cmd_init_rx;
   logic mem_sel;
   logic rx_glitch;
   logic tx_glitch;
   logic [BD_W-1:0] eng_data;
   logic [MEM_AW-1:0] eng_addr;
   logic [DATA_W-1:0] reg_data;
   logic filt_en;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;

   assign tx_en = mode[MODE_TXEN];
   assign rx_en = mode[MODE_RXEN];
   assign glitch_detect_enable = mode[MODE_GDE];
   assign cmd_wr = wr_en && hit(addr, REG_CMD);
   assign cmd = wr_data[CMD_W-1:0];
   // R14 whole-processor reset
   assign cmd_reset = cmd_wr && (cmd == CMD_RESET_CP);
   // R12 combined init hits both directions
   assign cmd_init_tx = cmd_wr && !tx_en &&
                        (cmd == CMD_INIT_TX || cmd == CMD_INIT_BOTH);
   assign cmd_init_rx = cmd_wr && !rx_en &&
                        (cmd == CMD_INIT_RX || cmd == CMD_INIT_BOTH);
   assign mem_sel = (addr[ADDR_W-1:MEM_AW+2] ==
                     MEM_BASE[ADDR_W-1:MEM_AW+2]);

   // ----------------------------------------------------------------
   // Registers written by software
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= MODE_RST;
      end else if (cmd_reset) begin
         mode <= MODE_RST;
      end else if (wr_en && hit(addr, REG_MODE)) begin
         mode <= wr_data[MODE_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mask <= EVT_RST;
      end else if (cmd_reset) begin
         mask <= EVT_RST;
      end else if (wr_en && hit(addr, REG_MASK)) begin
         mask <= wr_data[EVT_W-1:0];
      end
   end

   // R7 init restores transmit pointer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_ptr <= TX_PTR_RST;
      end else if (cmd_reset || cmd_init_tx) begin
         tx_ptr <= TX_PTR_RST;
      end else if (wr_en && hit(addr, REG_TXPTR)) begin
         tx_ptr <= wr_data[MEM_AW-1:0];
      end
   end

   // R11 init restores receive pointer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_ptr <= RX_PTR_RST;
      end else if (cmd_reset || cmd_init_rx) begin
         rx_ptr <= RX_PTR_RST;
      end else if (wr_en && hit(addr, REG_RXPTR)) begin
         rx_ptr <= wr_data[MEM_AW-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cp_reset_out <= 1'b0;
      end else begin
         cp_reset_out <= cmd_reset;
      end
   end

   // ----------------------------------------------------------------
   // Glitch filters and events
   // ----------------------------------------------------------------
   // R13 filters idle while both directions are off
   assign filt_en = glitch_detect_enable && (tx_en || rx_en);

   glitch_filter u_rx_filter (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .enable(filt_en),
      .clk_in(rx_clk_in),
      .clk_out(rx_clk_filt),
      .glitch(rx_glitch)
   );

   glitch_filter u_tx_filter (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .enable(filt_en),
      .clk_in(tx_clk_in),
      .clk_out(tx_clk_filt),
      .glitch(tx_glitch)
   );

   // R2 event per glitched clock
   assign evt_set = {tx_glitch, rx_glitch};
   // R17 write one or read clears
   assign evt_clr = (wr_en && hit(addr, REG_EVENT)) ?
                    wr_data[EVT_W-1:0] :
                    ((rd_en && hit(addr, REG_EVENT)) ? {EVT_W{1'b1}} :
                     EVT_RST);

   // A new event in the clearing cycle is kept: set wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         event_bits <= EVT_RST;
      end else if (cmd_reset) begin
         event_bits <= EVT_RST;
      end else begin
         event_bits <= (event_bits & ~evt_clr) | evt_set;
      end
   end

   // R17 masked interrupt
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_bits & mask);
      end
   end

   // ----------------------------------------------------------------
   // Transmitter and receiver control
   // ----------------------------------------------------------------
   // Transmit fetches win the shared engine port
   assign eng_addr = (tx_state == TX_FETCH) ? tx_ptr : rx_ptr;

   always_comb begin
      next_tx_state = tx_state;
      // R3 held in reset while disabled
      if (cmd_reset || !tx_en) begin
         next_tx_state = TX_OFF;
      end else if ((cmd_wr && (cmd == CMD_STOP_TX ||
                    cmd == CMD_GSTOP_TX)) && tx_state != TX_OFF) begin
         next_tx_state = TX_HALT;
      end else begin
         unique case (tx_state)
            TX_OFF: next_tx_state = TX_FETCH;
            TX_FETCH: next_tx_state = TX_CHECK;
            // R4 start once ready flag set
            TX_CHECK: next_tx_state = eng_data[TX_READY_BIT] ?
                                      TX_RUN : TX_FETCH;
            TX_RUN: next_tx_state = TX_RUN;
            TX_HALT: begin
               if (cmd_wr && cmd == CMD_RESTART_TX) begin
                  next_tx_state = TX_FETCH;
               end
            end
            default: next_tx_state = TX_OFF;
         endcase
      end
   end

   always_comb begin
      next_rx_state = rx_state;
      // R8 abort at once
      if (cmd_reset || !rx_en) begin
         next_rx_state = RX_OFF;
      end else begin
         unique case (rx_state)
            RX_OFF: next_rx_state = RX_FETCH;
            RX_FETCH: begin
               if (tx_state != TX_FETCH) begin
                  next_rx_state = RX_CHECK;
               end
            end
            // R10 begin when empty flag set
            RX_CHECK: next_rx_state = eng_data[RX_EMPTY_BIT] ?
                                      RX_RUN : RX_FETCH;
            RX_RUN: begin
               if (cmd_wr && cmd == CMD_HUNT) begin
                  next_rx_state = RX_FETCH;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_state <= TX_OFF;
         tx_run <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         tx_run <= (next_tx_state == TX_RUN);
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_state <= RX_OFF;
         rx_run <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         rx_run <= (next_rx_state == RX_RUN);
      end
   end

   // R13 minimal-power flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         low_power <= 1'b1;
      end else if (cmd_reset) begin
         low_power <= 1'b1;
      end else if (wr_en && hit(addr, REG_MODE)) begin
         low_power <= !wr_data[MODE_TXEN] && !wr_data[MODE_RXEN];
      end
   end

   // ----------------------------------------------------------------
   // Read mux and parameter memory
   // ----------------------------------------------------------------
   always_comb begin
      reg_data = '0;
      if (hit(addr, REG_MODE)) begin
         reg_data[MODE_W-1:0] = mode;
      end else if (hit(addr, REG_EVENT)) begin
         reg_data[EVT_W-1:0] = event_bits;
      end else if (hit(addr, REG_MASK)) begin
         reg_data[EVT_W-1:0] = mask;
      end else if (hit(addr, REG_TXPTR)) begin
         reg_data[MEM_AW-1:0] = tx_ptr;
      end else if (hit(addr, REG_RXPTR)) begin
         reg_data[MEM_AW-1:0] = rx_ptr;
      end else if (hit(addr, REG_STATUS)) begin
         reg_data[5:0] = {low_power, rx_state, tx_state};
      end
   end

   // R16 memory writes need no disable
   param_mem u_mem (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .we(wr_en && mem_sel),
      .waddr(addr[MEM_AW+1:2]),
      .wdata(wr_data[BD_W-1:0]),
      .bus_rd(rd_en),
      .bus_mem(mem_sel),
      .bus_addr(addr[MEM_AW+1:2]),
      .reg_data(reg_data),
      .rd_data(rd_data),
      .eng_addr(eng_addr),
      .eng_data(eng_data)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_reset_cmd;
      cmd_reset;
   endsequence
   sequence s_reset_pulse;
      cp_reset_out && !tx_en && !rx_en ##1 !cp_reset_out;
   endsequence

   property p_tx_hold;
      !tx_en |=> !tx_run && tx_state == TX_OFF;
   endproperty
   a_tx_hold: assert property (p_tx_hold) // R3
      else $error("transmitter ran while disabled");

   property p_tx_start;
      tx_en && tx_state == TX_CHECK && eng_data[TX_READY_BIT] && !cmd_wr
      |=> tx_run;
   endproperty
   a_tx_start: assert property (p_tx_start) // R4
      else $error("transmitter did not start on ready descriptor");

   property p_init_tx;
      cmd_init_tx |=> tx_ptr == TX_PTR_RST;
   endproperty
   a_init_tx: assert property (p_init_tx) // R7
      else $error("init transmit did not restore pointer");

   property p_rx_abort;
      !rx_en |=> !rx_run ##1 !rx_run [*2];
   endproperty
   a_rx_abort: assert property (p_rx_abort) // R8
      else $error("reception not aborted");

   property p_rx_begin;
      $rose(rx_en) |-> rx_state == RX_OFF ##1 rx_state == RX_FETCH;
   endproperty
   a_rx_begin: assert property (p_rx_begin) // R10
      else $error("receiver did not begin fetching");

   property p_low_power;
      !tx_en && !rx_en |-> low_power;
   endproperty
   a_low_power: assert property (p_low_power) // R13
      else $error("minimal power flag missing");

   property p_cp_reset;
      s_reset_cmd |=> s_reset_pulse;
   endproperty
   a_cp_reset: assert property (p_cp_reset) // R14
      else $error("processor reset did not disable channel");

   property p_glitch_evt;
      rx_glitch && !cmd_reset |=> event_bits[EVT_RXG] ##1 irq == mask[EVT_RXG]
         || irq;
   endproperty
   a_glitch_evt: assert property (p_glitch_evt) // R2
      else $error("receive glitch event not set");

   property p_irq_mask;
      (event_bits & mask) == EVT_RST |=> !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) // R17
      else $error("interrupt without unmasked event");
endmodule

/* File: core/serial_chan_pkg.sv */
/*
 Constants, register map, command codes and state types for one serial
 channel's enable, command and clock glitch control.
 Assumes a single 40 MHz system clock and a plain register port.
*/
// What this block does
// R1 - Filter received serial clocks against one-sample spikes when glitch detect enabled. Code also needs transmit or receive enable set.
// R2 - A detected spike sets the receive or transmit glitch event bit.
// R3 - Clearing transmit enable disables the transmitter and holds it in reset.
// R4 - After enabling, transmit starts at the pointed descriptor once its ready flag set.
// R5 - Software should stop an active transmitter before disabling it.
// R6 - Software restarts transmit before re-enabling, unless it issued init transmit.
// R7 - Init transmit while disabled restores transmit parameters to post-reset values.
// R8 - Clearing receive enable aborts reception at once and holds receiver in reset.
// R9 - Software enters hunt before re-enabling receive, unless it issued init receive.
// R10 - Enabling receive begins at the pointed descriptor when its empty flag set.
// R11 - Init receive while disabled restores receive parameters to post-reset values.
// R12 - Combined init reinitializes both directions; new protocol runs once both enabled.
// R13 - With both enables clear, the channel sits in minimal-power state.
// R14 - Reset command resets the whole processor and disables all serial units.
// R15 - Software uses a disable sequence before changing non-dynamic mode settings.
// R16 - Parameter memory writes are accepted without disabling the channel.
// R17 - Glitch event bits stay set until cleared; interrupt only when mask set.
// R18 - Level change accepted after two agreeing samples; one-sample revert is a glitch.
package serial_chan_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_EVENT = 8'h08;
   localparam logic [7:0] REG_MASK = 8'h0C;
   localparam logic [7:0] REG_TXPTR = 8'h10;
   localparam logic [7:0] REG_RXPTR = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] MEM_BASE = 8'h80;
   localparam int MEM_AW = 5;
   localparam int MODE_W = 3;
   localparam int MODE_TXEN = 0;
   localparam int MODE_RXEN = 1;
   localparam int MODE_GDE = 2;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam int EVT_W = 2;
   localparam int EVT_RXG = 0;
   localparam int EVT_TXG = 1;
   localparam logic [1:0] EVT_RST = 2'h0;
   // ----------------------------------------------------------------
   // Commands
   // ----------------------------------------------------------------
   localparam int CMD_W = 4;
   localparam logic [3:0] CMD_INIT_BOTH = 4'h0;
   localparam logic [3:0] CMD_INIT_RX = 4'h1;
   localparam logic [3:0] CMD_INIT_TX = 4'h2;
   localparam logic [3:0] CMD_HUNT = 4'h3;
   localparam logic [3:0] CMD_STOP_TX = 4'h4;
   localparam logic [3:0] CMD_GSTOP_TX = 4'h5;
   localparam logic [3:0] CMD_RESTART_TX = 4'h6;
   localparam logic [3:0] CMD_RESET_CP = 4'hF;
   // ----------------------------------------------------------------
   // Descriptors and pointers
   // ----------------------------------------------------------------
   localparam int BD_W = 16;
   localparam int TX_READY_BIT = 15;
   localparam int RX_EMPTY_BIT = 15;
   localparam logic [4:0] TX_PTR_RST = 5'h00;
   localparam logic [4:0] RX_PTR_RST = 5'h10;
   typedef enum logic [2:0] {
      TX_OFF = 3'b000,
      TX_FETCH = 3'b001,
      TX_CHECK = 3'b010,
      TX_RUN = 3'b011,
      TX_HALT = 3'b100
   } tx_state_e;
   typedef enum logic [1:0] {
      RX_OFF = 2'b00,
      RX_FETCH = 2'b01,
      RX_CHECK = 2'b10,
      RX_RUN = 2'b11
   } rx_state_e;
endpackage

/* File: core/glitch_filter.sv */
/*
 Spike filter and glitch detector for one serial clock input.
 Assumes the clock input is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module glitch_filter (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic clk_in,
   output logic clk_out,
   output logic glitch
);
   logic prev;

   // R1 filter or bypass
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prev <= 1'b0;
         clk_out <= 1'b0;
         glitch <= 1'b0;
      end else if (!enable) begin
         prev <= clk_in;
         clk_out <= clk_in;
         glitch <= 1'b0;
      end else begin
         prev <= clk_in;
         // R18 two agreeing samples
         if (clk_in == prev && clk_in != clk_out) begin
            clk_out <= clk_in;
         end
         // R18 single-sample revert
         glitch <= (prev != clk_out) && (clk_in == clk_out);
      end
   end
endmodule

/* File: core/param_mem.sv */
/*
 Channel parameter memory holding descriptors and parameters.
 One write port, a bus read port that also carries register read data,
 and an engine read port; both read results are registered.
*/
`timescale 1ns/1ps
module param_mem #(
   parameter int AW = serial_chan_pkg::MEM_AW,
   parameter int DW = serial_chan_pkg::BD_W
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic bus_rd,
   input wire logic bus_mem,
   input wire logic [AW-1:0] bus_addr,
   input wire logic [serial_chan_pkg::DATA_W-1:0] reg_data,
   output logic [serial_chan_pkg::DATA_W-1:0] rd_data,
   input wire logic [AW-1:0] eng_addr,
   output logic [DW-1:0] eng_data
);
   import serial_chan_pkg::*;
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= '0;
      end else if (!bus_rd) begin
         rd_data <= '0;
      end else if (bus_mem) begin
         rd_data <= {{(DATA_W-DW){1'b0}}, mem[bus_addr]};
      end else begin
         rd_data <= reg_data;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         eng_data <= '0;
      end else begin
         eng_data <= mem[eng_addr];
      end
   end
endmodule

/* File: tb/tb.sv */
/*
 Self-checking bench for serial_chan_ctrl: register cases from a table,
 then enable, command, glitch and reset scenarios.
 Assumes the design package is compiled first; the bench drives every port.
*/
`timescale 1ns/1ps
module tb;
   import serial_chan_pkg::*;
   typedef struct {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } row_s;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h0;
   logic [DATA_W-1:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic rx_clk_in = 1'b0;
   logic tx_clk_in = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic rx_clk_filt, tx_clk_filt, tx_run, rx_run, low_power, irq;
   logic cp_reset_out;
   logic [6:0] outs;
   int fail_count = 0;
   int samples_checked = 0;
   // Reads return the written value clipped to the register width; REG_CMD and unmapped 8'h20 read back 0
   row_s rows [13] = '{
      '{1'b0, REG_MODE, 32'h0, 32'h0},
      '{1'b0, REG_EVENT, 32'h0, 32'h0},
      '{1'b0, REG_TXPTR, 32'h0, 32'h0},
      '{1'b0, REG_RXPTR, 32'h0, 32'h10},
      '{1'b0, REG_STATUS, 32'h0, 32'h20},
      '{1'b1, REG_MASK, 32'h3, 32'h3},
      '{1'b1, REG_TXPTR, 32'hFFFFFFFF, 32'h1F},
      '{1'b1, REG_RXPTR, 32'h5, 32'h5},
      '{1'b1, 8'h8C, 32'hFFFF1234, 32'h1234},
      '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h0},
      '{1'b1, REG_CMD, 32'h7, 32'h0},
      '{1'b1, REG_MODE, 32'h4, 32'h4},
      '{1'b0, REG_STATUS, 32'h0, 32'h20}
   };

   // Index: 0 tx_run, 1 rx_run, 2 irq, 3 rx_clk_filt, 4 cp_reset, 5 low_power
   // 6 tx_clk_filt
   assign outs = {tx_clk_filt, low_power, cp_reset_out, rx_clk_filt, irq,
                  rx_run, tx_run};

   serial_chan_ctrl u_dut (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .addr(addr),
      .wr_data(wr_data),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rd_data(rd_data),
      .rx_clk_in(rx_clk_in),
      .tx_clk_in(tx_clk_in),
      .rx_clk_filt(rx_clk_filt),
      .tx_clk_filt(tx_clk_filt),
      .tx_run(tx_run),
      .rx_run(rx_run),
      .low_power(low_power),
      .irq(irq),
      .cp_reset_out(cp_reset_out)
   );

   always #12.5 sys_clk = ~sys_clk;

   // ---------------------------------------------------------------
   // Checks and bus tasks
   // ---------------------------------------------------------------
   task automatic bad(input string msg);
      fail_count++;
      $display("BAD t=%0t %s", $time, msg);
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
   endtask
   // Polls a bounded number of edges; lim 0 means the very next edge
   task automatic wait_out(input int idx, input logic val, input int lim);
      int n = 0;
      @(posedge sys_clk);
      #1;
      while (outs[idx] !== val && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      samples_checked++;
      if (outs[idx] !== val) bad($sformatf("output %0d not %b", idx, val));
   endtask
   task automatic hold_out(input int idx, input logic val, input int cyc);
      repeat (cyc) begin
         @(posedge sys_clk);
         #1;
         samples_checked++;
         if (outs[idx] !== val) bad($sformatf("output %0d left %b", idx, val));
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      chk_word(rd_data, exp);
   endtask
   task automatic cmd(input logic [3:0] c);
      wr(REG_CMD, {28'h0, c});
   endtask
   // One-sample pulse on one serial clock
   task automatic spike(input logic tx);
      @(posedge sys_clk);
      tx_clk_in <= tx;
      rx_clk_in <= !tx;
      @(posedge sys_clk);
      tx_clk_in <= 1'b0;
      rx_clk_in <= 1'b0;
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Far more than the sequence needs, so only a hang trips it
   initial begin
      #(25 * 5000);
      bad("watchdog expired");
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      cmd(CMD_INIT_TX);
      rd(REG_TXPTR, 32'h0);
      rd(REG_RXPTR, 32'h5);
      cmd(CMD_INIT_RX);
      rd(REG_RXPTR, 32'h10);
      wr(REG_TXPTR, 32'h9);
      wr(REG_RXPTR, 32'h3);
      cmd(CMD_INIT_BOTH);
      rd(REG_TXPTR, 32'h0);
      rd(REG_RXPTR, 32'h10);
      wr(8'h80, 32'h0);
      wr(REG_MODE, 32'h1);
      hold_out(0, 1'b0, 10);
      wr(8'h80, 32'h8000);
      wait_out(0, 1'b1, 12);
      wait_out(5, 1'b0, 0);
      rd(REG_STATUS, 32'h3);
      wr(REG_TXPTR, 32'h7);
      cmd(CMD_INIT_TX);
      rd(REG_TXPTR, 32'h7);
      wr(REG_TXPTR, 32'h0);
      cmd(CMD_STOP_TX);
      wait_out(0, 1'b0, 2);
      rd(REG_STATUS, 32'h4);
      cmd(CMD_RESTART_TX);
      wait_out(0, 1'b1, 12);
      cmd(CMD_GSTOP_TX);
      wait_out(0, 1'b0, 2);
      cmd(CMD_RESTART_TX);
      wait_out(0, 1'b1, 12);
      wr(REG_MODE, 32'h0);
      wait_out(0, 1'b0, 0);
      wait_out(5, 1'b1, 1);
      wr(8'hC0, 32'h8000);
      wr(REG_MODE, 32'h2);
      wait_out(1, 1'b1, 12);
      cmd(CMD_HUNT);
      wait_out(1, 1'b0, 2);
      wait_out(1, 1'b1, 12);
      rd(REG_STATUS, 32'h18);
      wr(REG_MODE, 32'h0);
      wait_out(1, 1'b0, 0);
      wr(REG_MODE, 32'h3);
      wait_out(0, 1'b1, 12);
      wait_out(1, 1'b1, 12);
      cmd(CMD_RESET_CP);
      // The pulse stands only in the cycle right after the command edge
      #1;
      chk_word({31'h0, cp_reset_out}, 32'h1);
      wait_out(4, 1'b0, 0);
      rd(REG_MODE, 32'h0);
      rd(8'h8C, 32'h1234);
      rd(REG_STATUS, 32'h20);
      wr(REG_MODE, 32'h5);
      spike(1'b0);
      hold_out(2, 1'b0, 4);
      rd(REG_EVENT, 32'h1);
      rd(REG_EVENT, 32'h0);
      @(posedge sys_clk);
      rx_clk_in <= 1'b1;
      wait_out(3, 1'b1, 3);
      rd(REG_EVENT, 32'h0);
      @(posedge sys_clk);
      rx_clk_in <= 1'b0;
      wait_out(3, 1'b0, 3);
      @(posedge sys_clk);
      tx_clk_in <= 1'b1;
      wait_out(6, 1'b1, 3);
      @(posedge sys_clk);
      tx_clk_in <= 1'b0;
      wait_out(6, 1'b0, 3);
      wr(REG_MASK, 32'h3);
      spike(1'b1);
      wait_out(2, 1'b1, 6);
      rd(REG_EVENT, 32'h2);
      wait_out(2, 1'b0, 2);
      spike(1'b0);
      hold_out(3, 1'b0, 4);
      wr(REG_EVENT, 32'h1);
      rd(REG_EVENT, 32'h0);
      wr(REG_MODE, 32'h1);
      spike(1'b0);
      hold_out(2, 1'b0, 4);
      rd(REG_EVENT, 32'h0);
      summarize();
   end
endmodule
